// >>> logic/sodsh_top.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "sodsh_defs.svh"

// Contract
// - Output A is the clock divided by the 34-bit A divide ratio.
// - With custom high time off, output A is high for half the ratio, rounded down (3 of 7 on an odd ratio).
// - With custom high time on, high pulse length comes from the high-time register.
// - Control bit 4 inverts output A when set.
// - Modes 001 and 010 add a once-per-second 25/75 or 75/25 marker.
// - Modes 011 and 100 add a once-per-two-seconds 25/75 or 75/25 marker.
// - Mode 000 is a regular clock; 101 to 111 behave the same.
// - Synthesizer zero: low two strength bits set general output zero 1x to 4x.
// - Other synthesizers apply strength to their differential output pair only.
// - Differential codes 000 to 101 select 8, 12, 14, 16, 24, 28 mA.
// - Differential codes 110 and 111 fall back to 8 mA.

module sodsh_top #(
   parameter logic [1:0] SYNTH_INDEX = 2'h0,
   parameter logic [31:0] MARK_CYCLES = `SODSH_MARK_CYCLES
) (
   input wire logic aclk, // System clock, 100 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [15:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [15:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   output logic out_a, // Shaped output clock A
   output logic [1:0] general_purpose_output_zero_strength, // 1x..4x code
   output logic diff_strength_active, // Strength drives a differential pair
   output logic [2:0] hp_strength_code, // Cleaned differential code
   output logic [4:0] hp_strength_ma, // Differential current in mA
   output logic [3:0] hp_pair_base // First high-performance output of the pair
);
   import sodsh_pkg::*;

   typedef struct packed {
      sodsh_regs_t regs;
      logic awready;
      logic wready;
      logic aw_held;
      logic [13:0] aw_idx;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] gp_strength;
      logic diff_active;
      logic [2:0] hp_code;
      logic [4:0] hp_ma;
      logic [3:0] pair_base;
   } sodsh_top_st_t;

   sodsh_top_st_t s;
   sodsh_top_st_t next_s;
   sodsh_cfg_t cfg;
   sodsh_stat_t stat;
   logic shaped;

   // ****************************************************************
   // Register read decode
   // ****************************************************************
   // Returns {hit, word}; reserved words answer zero but still hit
   function automatic logic [32:0] read_word(input sodsh_regs_t r, input sodsh_stat_t st,
                                             input logic [13:0] idx);
      logic [32:0] v;
      v = '0;
      if (idx == `SODSH_IDX_A_DIV_LO)
         v = {1'b1, r.a_div[31:0]};
      else if (idx == `SODSH_IDX_A_DIV_HI)
         v = {1'b1, 30'h0, r.a_div[33:32]};
      else if (idx == `SODSH_IDX_A_DRIVE)
         v = {1'b1, 29'h0, r.drive};
      else if (idx == `SODSH_IDX_A_CTRL)
         v = {1'b1, 26'h0, r.width_en, r.polarity, 1'b0, r.mode};
      else if (idx == `SODSH_IDX_A_HIGH)
         v = {1'b1, r.high_time};
      else if (idx == `SODSH_IDX_A_PHASE_LO || idx == `SODSH_IDX_A_PHASE_HI)
         v = {1'b1, 32'h0};
      else if (idx == `SODSH_IDX_STATUS)
         v = {1'b1, 29'h0, st.second_parity, st.mark_pending, st.out_level};
      else if (idx == `SODSH_IDX_B_DIV_LO)
         v = {1'b1, r.b_div[31:0]};
      else if (idx == `SODSH_IDX_B_DIV_HI)
         v = {1'b1, 30'h0, r.b_div[33:32]};
      read_word = v;
   endfunction

   // ****************************************************************
   // Register write decode
   // ****************************************************************
   // Phase offset and status words take writes without effect
   function automatic sodsh_regs_t write_word(input sodsh_regs_t r, input logic [13:0] idx,
                                              input logic [31:0] w);
      sodsh_regs_t n;
      n = r;
      if (idx == `SODSH_IDX_A_DIV_LO)
         n.a_div[31:0] = w;
      else if (idx == `SODSH_IDX_A_DIV_HI)
         n.a_div[33:32] = w[`SODSH_DIV_HI_MSB:0];
      else if (idx == `SODSH_IDX_A_DRIVE)
         n.drive = w[2:0];
      else if (idx == `SODSH_IDX_A_CTRL)
      begin
         n.width_en = w[`SODSH_CTRL_WIDTH_EN];
         n.polarity = w[`SODSH_CTRL_POL];
         n.mode = w[`SODSH_CTRL_MODE_MSB:0];
      end
      else if (idx == `SODSH_IDX_A_HIGH)
         n.high_time = w;
      else if (idx == `SODSH_IDX_B_DIV_LO)
         n.b_div[31:0] = w;
      else if (idx == `SODSH_IDX_B_DIV_HI)
         n.b_div[33:32] = w[`SODSH_DIV_HI_MSB:0];
      write_word = n;
   endfunction

   // Byte-lane merge of new data into the current word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] w,
                                               input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            m[i*8 +: 8] = w[i*8 +: 8];
      merge_bytes = m;
   endfunction

   // Differential current for a cleaned code
   function automatic logic [4:0] code_to_ma(input logic [2:0] c);
      logic [4:0] m;
      m = `SODSH_MA_8;
      case (c)
         3'h1: m = `SODSH_MA_12;
         3'h2: m = `SODSH_MA_14;
         3'h3: m = `SODSH_MA_16;
         3'h4: m = `SODSH_MA_24;
         3'h5: m = `SODSH_MA_28;
         default: m = `SODSH_MA_8;
      endcase
      code_to_ma = m;
   endfunction

   // ****************************************************************
   // Bus slave and drive decode
   // ****************************************************************
   // One write and one read in flight; address and data may arrive in either order
   always_comb
   begin
      logic [32:0] rd;
      logic [32:0] old;
      rd = '0;
      old = '0;
      next_s = s;
      if (s.bvalid && bready)
         next_s.bvalid = 1'b0;
      if (s.awready && awvalid)
      begin
         next_s.aw_held = 1'b1;
         next_s.aw_idx = awaddr[15:2];
      end
      if (s.wready && wvalid)
      begin
         next_s.w_held = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
      end
      if (next_s.aw_held && next_s.w_held && !next_s.bvalid)
      begin
         old = read_word(s.regs, stat, next_s.aw_idx);
         next_s.regs = write_word(s.regs, next_s.aw_idx,
                                  merge_bytes(old[31:0], next_s.wdata, next_s.wstrb));
         next_s.bresp = old[32] ? `SODSH_RESP_OKAY : `SODSH_RESP_SLVERR;
         next_s.bvalid = 1'b1;
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
      end
      if (s.rvalid && rready)
         next_s.rvalid = 1'b0;
      if (s.arready && arvalid)
      begin
         rd = read_word(s.regs, stat, araddr[15:2]);
         next_s.rdata = rd[31:0];
         next_s.rresp = rd[32] ? `SODSH_RESP_OKAY : `SODSH_RESP_SLVERR;
         next_s.rvalid = 1'b1;
      end
      // Readies are registered so each output leaves a flip-flop
      next_s.awready = !next_s.aw_held && !next_s.bvalid;
      next_s.wready = !next_s.w_held && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
      // Drive strength updates on the same edge as the register
      if (SYNTH_INDEX == 2'h0)
      begin
         next_s.gp_strength = next_s.regs.drive[1:0];
         next_s.diff_active = 1'b0;
         next_s.hp_code = `SODSH_DIFF_LOW_CODE;
         next_s.pair_base = 4'h0;
      end
      else
      begin
         next_s.gp_strength = `SODSH_GP_DEFAULT;
         next_s.diff_active = 1'b1;
         next_s.pair_base = 4'((SYNTH_INDEX - 2'h1) * `SODSH_HP_PAIR_STRIDE);
         if (next_s.regs.drive > `SODSH_DIFF_MAX_CODE)
            next_s.hp_code = `SODSH_DIFF_LOW_CODE;
         else
            next_s.hp_code = next_s.regs.drive;
      end
      next_s.hp_ma = code_to_ma(next_s.hp_code);
   end

   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.regs.a_div <= `SODSH_A_DIV_RST;
         s.regs.drive <= `SODSH_DRIVE_RST;
         s.regs.high_time <= `SODSH_HIGH_RST;
         s.regs.b_div <= `SODSH_B_DIV_RST;
         s.gp_strength <= `SODSH_GP_DEFAULT;
         s.hp_ma <= `SODSH_MA_8;
      end
      else
         s <= next_s;
   end

   // ****************************************************************
   // Output shaper
   // ****************************************************************
   assign cfg.div = s.regs.a_div;
   assign cfg.high_time = s.regs.high_time;
   assign cfg.width_en = s.regs.width_en;
   assign cfg.polarity = s.regs.polarity;
   assign cfg.mode = s.regs.mode;

   sodsh_shaper #(
      .MARK_CYCLES(MARK_CYCLES)
   ) u_shaper (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg),
      .stat(stat),
      .out_a(shaped)
   );

   // Port assignments; every value comes from a flip-flop
   assign out_a = shaped;
   assign awready = s.awready;
   assign wready = s.wready;
   assign bresp = s.bresp;
   assign bvalid = s.bvalid;
   assign arready = s.arready;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign rvalid = s.rvalid;
   assign general_purpose_output_zero_strength = s.gp_strength;
   assign diff_strength_active = s.diff_active;
   assign hp_strength_code = s.hp_code;
   assign hp_strength_ma = s.hp_ma;
   assign hp_pair_base = s.pair_base;

endmodule // sodsh_top

// >>> logic/sodsh_defs.svh
`ifndef SODSH_DEFS_SVH
`define SODSH_DEFS_SVH

// ****************************************************************
// Register word indices (byte address is four times the index)
// ****************************************************************
`define SODSH_IDX_A_DIV_LO 14'h0699
`define SODSH_IDX_A_DIV_HI 14'h069A
`define SODSH_IDX_A_DRIVE 14'h069E
`define SODSH_IDX_A_CTRL 14'h069F
`define SODSH_IDX_A_HIGH 14'h06A1
`define SODSH_IDX_A_PHASE_LO 14'h06A5
`define SODSH_IDX_A_PHASE_HI 14'h06A6
`define SODSH_IDX_STATUS 14'h06AA
`define SODSH_IDX_B_DIV_LO 14'h06AD
`define SODSH_IDX_B_DIV_HI 14'h06AE

// ****************************************************************
// Reset values
// ****************************************************************
`define SODSH_A_DIV_RST 34'h000000005
`define SODSH_DRIVE_RST 3'h3
`define SODSH_HIGH_RST 32'h00000000
`define SODSH_B_DIV_RST 34'h000000028

// ****************************************************************
// Field positions
// ****************************************************************
`define SODSH_CTRL_WIDTH_EN 5
`define SODSH_CTRL_POL 4
`define SODSH_CTRL_MODE_MSB 2
`define SODSH_DIV_HI_MSB 1
`define SODSH_STAT_OUT 0
`define SODSH_STAT_PEND 1
`define SODSH_STAT_PARITY 2

// ****************************************************************
// Clock modes and drive codes
// ****************************************************************
`define SODSH_MODE_REGULAR 3'h0
`define SODSH_MODE_PPS_25 3'h1
`define SODSH_MODE_PPS_75 3'h2
`define SODSH_MODE_PP2S_25 3'h3
`define SODSH_MODE_PP2S_75 3'h4
`define SODSH_DIFF_MAX_CODE 3'h5
`define SODSH_DIFF_LOW_CODE 3'h0
`define SODSH_GP_DEFAULT 2'h3
`define SODSH_HP_PAIR_STRIDE 4'h4
`define SODSH_MA_8 5'h08
`define SODSH_MA_12 5'h0C
`define SODSH_MA_14 5'h0E
`define SODSH_MA_16 5'h10
`define SODSH_MA_24 5'h18
`define SODSH_MA_28 5'h1C

// ****************************************************************
// Timing
// ****************************************************************
`define SODSH_CLK_PERIOD_NS 10
`define SODSH_MARK_PERIOD_NS 1000000000
`define SODSH_MARK_CYCLES (`SODSH_MARK_PERIOD_NS / `SODSH_CLK_PERIOD_NS)
`define SODSH_MIN_DIV 34'h000000002

// ****************************************************************
// Bus answers
// ****************************************************************
`define SODSH_RESP_OKAY 2'h0
`define SODSH_RESP_SLVERR 2'h2

`endif

// >>> logic/sodsh_pkg.sv
package sodsh_pkg;

   // Settings handed from the register file to the shaper
   typedef struct packed {
      logic [33:0] div;
      logic [31:0] high_time;
      logic width_en;
      logic polarity;
      logic [2:0] mode;
   } sodsh_cfg_t;

   // Duty used for the current output period
   typedef enum logic [1:0] {
      SODSH_DUTY_NORMAL,
      SODSH_DUTY_QUARTER,
      SODSH_DUTY_THREE_Q
   } sodsh_duty_t;

   // State reported back from the shaper
   typedef struct packed {
      logic out_level;
      logic mark_pending;
      logic second_parity;
   } sodsh_stat_t;

   // Software-visible register contents
   typedef struct packed {
      logic [33:0] a_div;
      logic [2:0] drive;
      logic width_en;
      logic polarity;
      logic [2:0] mode;
      logic [31:0] high_time;
      logic [33:0] b_div;
   } sodsh_regs_t;

endpackage

// >>> logic/sodsh_shaper.sv
`timescale 1ns/100ps
`include "sodsh_defs.svh"

module sodsh_shaper #(
   parameter logic [31:0] MARK_CYCLES = `SODSH_MARK_CYCLES
) (
   input wire logic aclk, // Divider clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire sodsh_pkg::sodsh_cfg_t cfg, // Live register settings
   output sodsh_pkg::sodsh_stat_t stat, // Shaper state
   output logic out_a // Shaped output clock
);
   import sodsh_pkg::*;

   typedef struct packed {
      sodsh_cfg_t act;
      logic [33:0] cnt;
      logic [33:0] hi_len;
      logic [31:0] sec_cnt;
      logic parity;
      logic pending;
      logic out;
   } sodsh_shp_st_t;

   sodsh_shp_st_t s;
   sodsh_shp_st_t next_s;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic is_pps(input logic [2:0] m);
      is_pps = (m == `SODSH_MODE_PPS_25) || (m == `SODSH_MODE_PPS_75);
   endfunction

   function automatic logic is_pp2s(input logic [2:0] m);
      is_pp2s = (m == `SODSH_MODE_PP2S_25) || (m == `SODSH_MODE_PP2S_75);
   endfunction

   // ****************************************************************
   // Divider, marker and shaping
   // ****************************************************************
   // Settings are sampled only at the period boundary so a write never cuts a pulse
   always_comb
   begin
      logic [33:0] d;
      logic tick;
      sodsh_duty_t duty;
      d = '0;
      tick = 1'b0;
      duty = SODSH_DUTY_NORMAL;
      next_s = s;
      // Second timer; runs free so markers stay whole seconds apart
      tick = (s.sec_cnt == MARK_CYCLES - 32'h1);
      next_s.sec_cnt = tick ? '0 : s.sec_cnt + 32'h1;
      if (tick)
         next_s.parity = ~s.parity;
      if (s.cnt >= s.act.div - 34'h1 || s.act.div < `SODSH_MIN_DIV)
      begin
         next_s.cnt = '0;
         next_s.act = cfg;
         if (s.pending)
         begin
            next_s.pending = 1'b0;
            if (s.act.mode == `SODSH_MODE_PPS_25 || s.act.mode == `SODSH_MODE_PP2S_25)
               duty = SODSH_DUTY_QUARTER;
            else if (s.act.mode == `SODSH_MODE_PPS_75 || s.act.mode == `SODSH_MODE_PP2S_75)
               duty = SODSH_DUTY_THREE_Q;
         end
         // Ratios below two cannot toggle, so they run as two
         d = (cfg.div < `SODSH_MIN_DIV) ? `SODSH_MIN_DIV : cfg.div;
         next_s.act.div = d;
         case (duty)
            SODSH_DUTY_QUARTER: next_s.hi_len = d >> 2;
            SODSH_DUTY_THREE_Q: next_s.hi_len = d - (d >> 2);
            default:
            begin
               if (cfg.width_en)
                  next_s.hi_len = {2'h0, cfg.high_time};
               else
                  next_s.hi_len = d >> 1;
            end
         endcase
      end
      else
         next_s.cnt = s.cnt + 34'h1;
      // Set wins over consumption; invalid codes never arm a marker
      if (tick && is_pps(s.act.mode))
         next_s.pending = 1'b1;
      if (tick && is_pp2s(s.act.mode) && !s.parity)
         next_s.pending = 1'b1;
      next_s.out = (next_s.cnt < next_s.hi_len) ^ next_s.act.polarity;
   end

   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.act.div <= `SODSH_A_DIV_RST;
         s.hi_len <= `SODSH_A_DIV_RST >> 1;
         s.out <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign out_a = s.out;
   assign stat.out_level = s.out;
   assign stat.mark_pending = s.pending;
   assign stat.second_parity = s.parity;

endmodule // sodsh_shaper

// >>> verification/sodsh_chk.sv
`timescale 1ns/100ps
`include "sodsh_defs.svh"

// ****
// Bus handshake and drive code checker
// ****
module sodsh_chk #(
   parameter logic [1:0] SYNTH_INDEX = 2'h0,
   parameter logic [31:0] MARK_CYCLES = 32'h05F5E100
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic [15:0] awaddr, // Write address
   input wire logic awvalid, // Address valid
   input wire logic awready, // Address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic wvalid, // Data valid
   input wire logic wready, // Data ready
   input wire logic [1:0] bresp, // Write answer
   input wire logic bvalid, // Answer valid
   input wire logic bready, // Answer ready
   input wire logic arvalid, // Read valid
   input wire logic arready, // Read ready
   input wire logic [31:0] rdata, // Read data
   input wire logic [1:0] rresp, // Read answer
   input wire logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire logic [1:0] general_purpose_output_zero_strength, // 1x..4x
   input wire logic diff_strength_active, // Pair mode
   input wire logic [2:0] hp_strength_code, // Pair code
   input wire logic [4:0] hp_strength_ma, // Pair current
   input wire logic [3:0] hp_pair_base // Pair base
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Current of each pair code; invalid codes fall back to the lowest
   function automatic logic [4:0] ma_of(input logic [2:0] c);
      case (c)
         3'h1: return 5'h0C;
         3'h2: return 5'h0E;
         3'h3: return 5'h10;
         3'h4: return 5'h18;
         3'h5: return 5'h1C;
         default: return 5'h08;
      endcase
   endfunction

   // First output of the pair served by this synthesizer
   logic [3:0] pair_exp;
   assign pair_exp = (SYNTH_INDEX == 2'h0) ? 4'h0 : {SYNTH_INDEX - 2'h1, 2'h0};

   property p_bresp_stand;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_bresp_stand: assert property (p_bresp_stand) else $error("write answer dropped early");
   property p_rdata_stand;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_rdata_stand: assert property (p_rdata_stand) else $error("read answer dropped early");
   property p_b_after_w;
      awvalid && awready && wvalid && wready |=> bvalid;
   endproperty
   a_b_after_w: assert property (p_b_after_w) else $error("write answer late");
   property p_r_after_ar;
      arvalid && arready |=> rvalid;
   endproperty
   a_r_after_ar: assert property (p_r_after_ar) else $error("read answer late");
   property p_busy_write;
      bvalid |-> !awready && !wready;
   endproperty
   a_busy_write: assert property (p_busy_write) else $error("write taken while answer open");
   property p_busy_read;
      rvalid |-> !arready;
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("read taken while answer open");
   // Skip the first edge after reset: the registered outputs load there
   property p_pair_map;
      $past(aresetn) |-> diff_strength_active == (SYNTH_INDEX != 2'h0) && hp_pair_base == pair_exp;
   endproperty
   a_pair_map: assert property (p_pair_map) else $error("pair routing wrong");
   property p_ma_table;
      $past(aresetn) && diff_strength_active |-> hp_strength_code <= 3'h5
         && hp_strength_ma == ma_of(hp_strength_code);
   endproperty
   a_ma_table: assert property (p_ma_table) else $error("pair current wrong");
   property p_drive_follow;
      logic [2:0] v;
      (awvalid && awready && wvalid && wready && awaddr[15:2] == `SODSH_IDX_A_DRIVE, v = wdata[2:0])
         |=> (SYNTH_INDEX == 2'h0 ? general_purpose_output_zero_strength == v[1:0]
         : hp_strength_code == (v > 3'h5 ? 3'h0 : v));
   endproperty
   a_drive_follow: assert property (p_drive_follow) else $error("drive code not applied");
endmodule // sodsh_chk

bind sodsh_top sodsh_chk #(.SYNTH_INDEX(SYNTH_INDEX), .MARK_CYCLES(MARK_CYCLES)) u_chk (.*);

// >>> verification/sodsh_tb.sv
`timescale 1ns/100ps
`include "sodsh_defs.svh"

module testbench;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, out_a, diff_strength_active, dif2;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, hp_pair_base, base2;
   logic [1:0] bresp, rresp, general_purpose_output_zero_strength, gp2;
   logic [2:0] hp_strength_code, code2;
   logic [4:0] hp_strength_ma, ma2;
   logic [4:0] ma_tab [8] = '{5'h08, 5'h0C, 5'h0E, 5'h10, 5'h18, 5'h1C, 5'h08, 5'h08};
   int marks_exp [8] = '{0, 4, 4, 2, 2, 0, 0, 0};
   int error_cnt, total_checks, hi, per, marks;
   realtime t0;

   // Short second tick keeps the marker runs brief
   sodsh_top #(.SYNTH_INDEX(2'h0), .MARK_CYCLES(32'h000000C8)) DUT (.*);
   // Second instance shares the bus to watch the differential drive path
   sodsh_top #(.SYNTH_INDEX(2'h2), .MARK_CYCLES(32'h000000C8)) DUT_HP (.*, .awready(), .wready(),
      .bresp(), .bvalid(), .arready(), .rdata(), .rresp(), .rvalid(), .out_a(),
      .general_purpose_output_zero_strength(gp2), .diff_strength_active(dif2),
      .hp_strength_code(code2), .hp_strength_ma(ma2), .hp_pair_base(base2));

   // Clock at 100 MHz
   initial
   begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   // ****
   // Bus tasks and comparisons
   // ****
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wchk(input logic [13:0] i, input logic [31:0] d, input logic [1:0] er);
      logic a, w;
      a = 1'h1;
      w = 1'h1;
      awaddr <= {i, 2'h0};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (a || w)
      begin
         @(posedge aclk);
         if (awready) a = 1'h0;
         if (wready) w = 1'h0;
         awvalid <= a;
         wvalid <= w;
      end
      // Ready is raised late on purpose so the answer has to stand
      while (bvalid !== 1'h1) @(posedge aclk);
      bready <= 1'h1;
      @(posedge aclk);
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      bready <= 1'h0;
   endtask

   task automatic rchk(input string n, input logic [13:0] i, input logic [31:0] e, input logic [1:0] er);
      araddr <= {i, 2'h0};
      arvalid <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      while (rvalid !== 1'h1) @(posedge aclk);
      rready <= 1'h1;
      @(posedge aclk);
      chk(n, e, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      rready <= 1'h0;
   endtask

   // Waits for a rising output edge
   task automatic sync_rise();
      while (out_a !== 1'h0) @(posedge aclk);
      while (out_a !== 1'h1) @(posedge aclk);
   endtask

   // Measures one period from a rise to the next rise
   task automatic meas();
      int lo;
      hi = 0;
      lo = 0;
      while (out_a === 1'h1 && hi < 300) @(posedge aclk) hi++;
      while (out_a === 1'h0 && lo < 300) @(posedge aclk) lo++;
      per = hi + lo;
   endtask

   task automatic shape(input logic [31:0] ctrl, input int ehi, input int eper);
      wchk(`SODSH_IDX_A_CTRL, ctrl, 2'h0);
      repeat (20) @(posedge aclk);
      sync_rise();
      meas();
      chk("period", eper, per);
      chk("high", ehi, hi);
   endtask

   task automatic stop_test();
      $display("Checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ****
   // Test sequence
   // ****
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = 64'h0;
      wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      rchk("div_lo", `SODSH_IDX_A_DIV_LO, 32'h00000005, 2'h0);
      rchk("div_hi", `SODSH_IDX_A_DIV_HI, 32'h00000000, 2'h0);
      rchk("drive", `SODSH_IDX_A_DRIVE, 32'h00000003, 2'h0);
      rchk("ctrl", `SODSH_IDX_A_CTRL, 32'h00000000, 2'h0);
      rchk("high", `SODSH_IDX_A_HIGH, 32'h00000000, 2'h0);
      rchk("b_div", `SODSH_IDX_B_DIV_LO, 32'h00000028, 2'h0);
      chk("gp_rst", 32'h3, {30'h0, general_purpose_output_zero_strength});
      // Unmapped place refuses; reserved phase word ignores writes
      rchk("unmapped", 14'h0698, 32'h0, 2'h2);
      wchk(14'h0698, 32'hFFFFFFFF, 2'h2);
      wchk(`SODSH_IDX_A_PHASE_LO, 32'hFFFFFFFF, 2'h0);
      rchk("phase", `SODSH_IDX_A_PHASE_LO, 32'h0, 2'h0);
      rchk("b_div_hi", `SODSH_IDX_B_DIV_HI, 32'h0, 2'h0);
      wchk(`SODSH_IDX_STATUS, 32'hFFFFFFFF, 2'h0);
      // Every drive code on both synthesizer kinds
      for (int c = 0; c < 8; c++)
      begin
         wchk(`SODSH_IDX_A_DRIVE, c, 2'h0);
         repeat (3) @(posedge aclk);
         chk("gp", c % 4, {30'h0, general_purpose_output_zero_strength});
         chk("hp_code", (c > 5) ? 0 : c, {29'h0, code2});
         chk("hp_ma", {27'h0, ma_tab[c]}, {27'h0, ma2});
         chk("gp_hp", 32'h3, {30'h0, gp2});
         chk("gp_pair_drive", 32'h08, {24'h0, hp_strength_code, hp_strength_ma});
         rchk("drive", `SODSH_IDX_A_DRIVE, c, 2'h0);
      end
      chk("gp_pair", 32'h0, {31'h0, diff_strength_active});
      chk("hp_pair", 32'h1, {31'h0, dif2});
      chk("hp_base", 32'h4, {28'h0, base2});
      chk("gp_base", 32'h0, {28'h0, hp_pair_base});
      // Duty, polarity and custom high time on an odd ratio
      wchk(`SODSH_IDX_A_DIV_LO, 32'h7, 2'h0);
      wchk(`SODSH_IDX_A_HIGH, 32'h2, 2'h0);
      shape(32'h00, 3, 7);
      shape(32'h10, 4, 7);
      shape(32'h20, 2, 7);
      // Every mode: marker count and duty over four second ticks
      wchk(`SODSH_IDX_A_DIV_LO, 32'h8, 2'h0);
      for (int m = 0; m < 8; m++)
      begin
         wchk(`SODSH_IDX_A_CTRL, m, 2'h0);
         repeat (240) @(posedge aclk);
         sync_rise();
         marks = 0;
         for (int p = 0; p < 100; p++)
         begin
            meas();
            chk("mode_period", 8, per);
            if (hi != 4) marks++;
            if (hi != 4) chk("mark_high", (m == 1 || m == 3) ? 2 : 6, hi);
         end
         chk("marks", marks_exp[m], marks);
      end
      // Ratio change mid-period must not cut the running period short
      sync_rise();
      t0 = $realtime;
      wchk(`SODSH_IDX_A_DIV_LO, 32'hC, 2'h0);
      sync_rise();
      chk("old_period", 8, int'(($realtime - t0) / 10.0));
      meas();
      chk("new_period", 12, per);
      chk("new_high", 6, hi);
      stop_test();
   end

   // Cuts a hang short; the sequence needs about 10000 cycles
   initial
   begin
      repeat (40000) @(posedge aclk);
      error_cnt++;
      stop_test();
   end
endmodule // testbench
